// *** hw/scs_clock_select.sv ***
// System clock source select, prescaler and flash timing control top level.
`include "scs_consts.svh"

// Notes on behaviour
// - Select code 11 drives the system clock straight from the direct clock input.
// - Select code 10 with bypass set divides the oscillator or internal source by the divide field plus one.
// - A divide factor of one passes the source through with its own duty cycle.
// - The divide factor reaches 1024 at most, the slowest system clock.
// - Wait states are paid in full only by non-sequential flash fetches; prefetch hides all or part of them for sequential ones.
// - Flash contents are read ahead of demand so sequential fetches finish sooner.
// - Erase or program runs beside fetches from one other module or RAM, never on the module being fetched from.
// - Each erase or program spends four extra ref_clk cycles in the control sequencer.
// - Select code 10 with bypass clear enables the PLL and uses its output.
// - Select code 00 runs the system clock from the wakeup source.
module scs_clock_select #(
  parameter int ERASE_CYC = `SCS_ERASE_CYC,
  parameter int PROG_CYC = `SCS_PROG_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`SCS_ADDR_W-1:0] regAddr,
  input wire logic [`SCS_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`SCS_DATA_W-1:0] regRdData,
  input wire logic wakeupClkIn,
  input wire logic pllClkIn,
  input wire logic directClkIn,
  input wire logic crystalIn,
  input wire logic intClkIn,
  output logic sysClk,
  output logic pllEnable,
  input wire logic fetchReq,
  input wire logic fetchFromRam,
  input wire logic [`SCS_FL_MOD_W-1:0] fetchModule,
  input wire logic [`SCS_FL_ADDR_W-1:0] fetchAddr,
  output logic fetchAck,
  output logic [`SCS_DATA_W-1:0] fetchData,
  output logic arrRdEn,
  output logic [`SCS_FL_MOD_W-1:0] arrModule,
  output logic [`SCS_FL_ADDR_W-1:0] arrAddr,
  input wire logic [`SCS_DATA_W-1:0] arrRdData
);

  scs_pkg::scs_top_s s;
  scs_pkg::scs_top_s n;
  scs_pkg::scs_src_e tgtSrc;
  logic [`SCS_PREDIV_W-1:0] tgtDiv;
  logic [2:0] pinSel;
  logic srcEdge;
  logic srcRise;
  logic change;
  logic opBusy;
  logic opRefused;

  function automatic scs_pkg::scs_src_e decodeSrc(
    input logic [1:0] sel,
    input logic bypass,
    input scs_pkg::scs_src_e hold
  );
    case (sel)
      `SCS_SRCSEL_WAKEUP: decodeSrc = scs_pkg::SCS_SRC_WAKEUP;
      `SCS_SRCSEL_PRESCALE: decodeSrc = bypass ?
        scs_pkg::SCS_SRC_PRESCALE : scs_pkg::SCS_SRC_PLL;
      `SCS_SRCSEL_DIRECT: decodeSrc = scs_pkg::SCS_SRC_DIRECT;
      default: decodeSrc = hold;
    endcase
  endfunction : decodeSrc

  function automatic logic [2:0] pinIndex(
    input scs_pkg::scs_src_e src,
    input logic osc
  );
    case (src)
      scs_pkg::SCS_SRC_WAKEUP: pinIndex = `SCS_PIN_WAKEUP;
      scs_pkg::SCS_SRC_PLL: pinIndex = `SCS_PIN_PLL;
      scs_pkg::SCS_SRC_DIRECT: pinIndex = `SCS_PIN_DIRECT;
      default: pinIndex = osc ? `SCS_PIN_INTERNAL : `SCS_PIN_CRYSTAL;
    endcase
  endfunction : pinIndex

  always_comb
  begin
    n = s;
    n.rdData = '0;
    n.opStart = 1'b0;
    n.sync1 = {intClkIn, crystalIn, directClkIn, pllClkIn, wakeupClkIn};
    n.sync2 = s.sync1;
    n.prev = s.sync2;
    if (regWr)
    begin
      case (regAddr)
        `SCS_ADDR_SYSCTL0: n.srcSel = regWrData[`SCS_SRCSEL_LSB +: 2];
        `SCS_ADDR_PLLCTL0:
        begin
          n.vcoBypass = regWrData[`SCS_BYPASS_BIT];
          n.oscInternal = regWrData[`SCS_OSCINT_BIT];
          n.divField = regWrData[`SCS_PREDIV_LSB +: `SCS_PREDIV_W];
        end
        `SCS_ADDR_FLCTL:
          n.waitStates = regWrData[`SCS_WAITST_LSB +: `SCS_WAITST_W];
        `SCS_ADDR_FLCMD:
        begin
          n.opStart = 1'b1;
          n.opErase = regWrData[`SCS_CMD_ERASE_BIT];
          n.opModule = regWrData[`SCS_CMD_MOD_LSB +: `SCS_FL_MOD_W];
        end
        default:
        begin
        end
      endcase
    end
    tgtSrc = decodeSrc(s.srcSel, s.vcoBypass, s.actSrc);
    // Ten bits of divide field give factors 1 to 1024.
    tgtDiv = (tgtSrc == scs_pkg::SCS_SRC_PRESCALE) ? s.divField : '0;
    change = (tgtSrc != s.actSrc) || (tgtDiv != s.actDiv) ||
      ((tgtSrc == scs_pkg::SCS_SRC_PRESCALE) && (s.oscInternal != s.actOsc));
    pinSel = pinIndex(s.actSrc, s.actOsc);
    srcEdge = s.sync2[pinSel] ^ s.prev[pinSel];
    srcRise = s.sync2[pinSel] & ~s.prev[pinSel];
    // Each half period spans divide-plus-one source edges, so a factor of one
    // follows every source edge and keeps the source duty cycle.
    case (s.phase)
      scs_pkg::SCS_PH_HIGH:
      begin
        if (srcEdge)
        begin
          if (s.edgeCnt == s.actDiv)
          begin
            n.sysClk = 1'b0;
            n.phase = scs_pkg::SCS_PH_LOW;
            n.edgeCnt = '0;
          end
          else
          begin
            n.edgeCnt = s.edgeCnt + 10'h001;
          end
        end
      end
      scs_pkg::SCS_PH_LOW:
      begin
        if (srcEdge)
        begin
          if (s.edgeCnt != s.actDiv)
          begin
            n.edgeCnt = s.edgeCnt + 10'h001;
          end
          else if (change)
          begin
            // Switch only at the end of a full low phase and hold low until
            // the new source rises, so no shortened pulse can appear.
            n.actSrc = tgtSrc;
            n.actDiv = tgtDiv;
            n.actOsc = s.oscInternal;
            n.phase = scs_pkg::SCS_PH_WAIT_RISE;
            n.edgeCnt = '0;
          end
          else
          begin
            n.sysClk = 1'b1;
            n.phase = scs_pkg::SCS_PH_HIGH;
            n.edgeCnt = '0;
          end
        end
      end
      scs_pkg::SCS_PH_WAIT_RISE:
      begin
        // A new source that never toggles leaves the clock parked low.
        if (srcRise)
        begin
          n.sysClk = 1'b1;
          n.phase = scs_pkg::SCS_PH_HIGH;
          n.edgeCnt = '0;
        end
      end
      default:
      begin
        n.sysClk = 1'b0;
        n.phase = scs_pkg::SCS_PH_WAIT_RISE;
      end
    endcase
    // The PLL stays enabled until the output has left it.
    n.pllEnable = (tgtSrc == scs_pkg::SCS_SRC_PLL) ||
      (s.actSrc == scs_pkg::SCS_SRC_PLL);
    if (regRd)
    begin
      case (regAddr)
        `SCS_ADDR_SYSCTL0: n.rdData[`SCS_SRCSEL_LSB +: 2] = s.srcSel;
        `SCS_ADDR_PLLCTL0:
        begin
          n.rdData[`SCS_BYPASS_BIT] = s.vcoBypass;
          n.rdData[`SCS_OSCINT_BIT] = s.oscInternal;
          n.rdData[`SCS_PREDIV_LSB +: `SCS_PREDIV_W] = s.divField;
        end
        `SCS_ADDR_FLCTL:
          n.rdData[`SCS_WAITST_LSB +: `SCS_WAITST_W] = s.waitStates;
        `SCS_ADDR_FLCMD:
        begin
          n.rdData[`SCS_STAT_BUSY_BIT] = opBusy;
          n.rdData[`SCS_STAT_REFUSED_BIT] = opRefused;
        end
        `SCS_ADDR_CLKSTAT:
        begin
          n.rdData[1:0] = s.actSrc;
          n.rdData[`SCS_PREDIV_LSB +: `SCS_PREDIV_W] = s.actDiv;
          n.rdData[`SCS_STAT_PEND_BIT] = change;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.srcSel <= `SCS_RST_SRCSEL;
      s.vcoBypass <= `SCS_RST_BYPASS;
      s.oscInternal <= `SCS_RST_OSCINT;
      s.divField <= `SCS_RST_PREDIV;
      s.waitStates <= `SCS_RST_WAITST;
      s.actSrc <= scs_pkg::SCS_SRC_WAKEUP;
      s.actOsc <= `SCS_RST_OSCINT;
      s.phase <= scs_pkg::SCS_PH_WAIT_RISE;
    end
    else
    begin
      s <= n;
    end
  end

  scs_flash_ctl #(
    .ERASE_CYC(ERASE_CYC[`SCS_FL_OPCNT_W-1:0]),
    .PROG_CYC(PROG_CYC[`SCS_FL_OPCNT_W-1:0])
  ) u_flash (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .waitStates(s.waitStates),
    .fetchReq(fetchReq),
    .fetchFromRam(fetchFromRam),
    .fetchModule(fetchModule),
    .fetchAddr(fetchAddr),
    .fetchAck(fetchAck),
    .fetchData(fetchData),
    .arrRdEn(arrRdEn),
    .arrModule(arrModule),
    .arrAddr(arrAddr),
    .arrRdData(arrRdData),
    .opStart(s.opStart),
    .opErase(s.opErase),
    .opModule(s.opModule),
    .opBusy(opBusy),
    .opRefused(opRefused)
  );

  assign regRdData = s.rdData;
  assign sysClk = s.sysClk;
  assign pllEnable = s.pllEnable;

endmodule : scs_clock_select

// *** shared/scs_consts.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

`define SCS_ADDR_W 4
`define SCS_DATA_W 16

`define SCS_ADDR_SYSCTL0 4'h0
`define SCS_ADDR_PLLCTL0 4'h1
`define SCS_ADDR_FLCTL 4'h2
`define SCS_ADDR_FLCMD 4'h3
`define SCS_ADDR_CLKSTAT 4'h4

`define SCS_SRCSEL_LSB 0
`define SCS_BYPASS_BIT 0
`define SCS_OSCINT_BIT 1
`define SCS_PREDIV_LSB 2
`define SCS_PREDIV_W 10
`define SCS_WAITST_LSB 0
`define SCS_WAITST_W 3
`define SCS_CMD_ERASE_BIT 0
`define SCS_CMD_MOD_LSB 1
`define SCS_STAT_BUSY_BIT 0
`define SCS_STAT_REFUSED_BIT 1
`define SCS_STAT_PEND_BIT 12

`define SCS_SRCSEL_WAKEUP 2'h0
`define SCS_SRCSEL_PRESCALE 2'h2
`define SCS_SRCSEL_DIRECT 2'h3

`define SCS_RST_SRCSEL 2'h0
`define SCS_RST_BYPASS 1'h1
`define SCS_RST_OSCINT 1'h1
`define SCS_RST_PREDIV 10'h000
`define SCS_RST_WAITST 3'h4

`define SCS_NUM_PINS 5
`define SCS_PIN_WAKEUP 3'h0
`define SCS_PIN_PLL 3'h1
`define SCS_PIN_DIRECT 3'h2
`define SCS_PIN_CRYSTAL 3'h3
`define SCS_PIN_INTERNAL 3'h4

`define SCS_FL_ADDR_W 16
`define SCS_FL_MOD_W 2
`define SCS_FL_OPCNT_W 20
`define SCS_CLK_MHZ 100
`define SCS_ERASE_TIME_US 8000
`define SCS_PROG_TIME_US 3500
`define SCS_ERASE_CYC (`SCS_ERASE_TIME_US * `SCS_CLK_MHZ)
`define SCS_PROG_CYC (`SCS_PROG_TIME_US * `SCS_CLK_MHZ)
`define SCS_FL_OVERHEAD_CYC 20'h00004

`endif

// *** shared/scs_pkg.sv ***
// Types shared by the clock select block and its flash access controller.
`include "scs_consts.svh"

package scs_pkg;

  typedef enum logic [1:0] {
    SCS_SRC_WAKEUP,
    SCS_SRC_PLL,
    SCS_SRC_PRESCALE,
    SCS_SRC_DIRECT
  } scs_src_e;

  typedef enum logic [1:0] {
    SCS_PH_LOW,
    SCS_PH_HIGH,
    SCS_PH_WAIT_RISE
  } scs_phase_e;

  typedef enum logic [1:0] {
    SCS_OP_IDLE,
    SCS_OP_OVERHEAD,
    SCS_OP_TIMED
  } scs_op_e;

  typedef struct packed {
    logic [`SCS_NUM_PINS-1:0] sync1;
    logic [`SCS_NUM_PINS-1:0] sync2;
    logic [`SCS_NUM_PINS-1:0] prev;
    logic [1:0] srcSel;
    logic vcoBypass;
    logic oscInternal;
    logic [`SCS_PREDIV_W-1:0] divField;
    logic [`SCS_WAITST_W-1:0] waitStates;
    scs_src_e actSrc;
    logic actOsc;
    logic [`SCS_PREDIV_W-1:0] actDiv;
    logic [`SCS_PREDIV_W-1:0] edgeCnt;
    scs_phase_e phase;
    logic sysClk;
    logic pllEnable;
    logic opStart;
    logic opErase;
    logic [`SCS_FL_MOD_W-1:0] opModule;
    logic [`SCS_DATA_W-1:0] rdData;
  } scs_top_s;

  typedef struct packed {
    logic engBusy;
    logic engDemand;
    logic [`SCS_FL_ADDR_W-1:0] engAddr;
    logic [`SCS_FL_MOD_W-1:0] engModule;
    logic [`SCS_WAITST_W-1:0] engCnt;
    logic pfValid;
    logic [`SCS_FL_ADDR_W-1:0] pfAddr;
    logic [`SCS_FL_MOD_W-1:0] pfModule;
    logic [`SCS_DATA_W-1:0] pfData;
    logic ack;
    logic [`SCS_DATA_W-1:0] data;
    logic [`SCS_FL_MOD_W-1:0] activeModule;
    logic ramActive;
    scs_op_e opState;
    logic opErase;
    logic [`SCS_FL_MOD_W-1:0] opModule;
    logic [`SCS_FL_OPCNT_W-1:0] opCnt;
    logic refused;
  } scs_flash_s;

endpackage : scs_pkg

// *** hw/scs_flash_ctl.sv ***
// Flash fetch timing with prefetch, and erase or program sequencing.
`include "scs_consts.svh"

module scs_flash_ctl #(
  parameter logic [`SCS_FL_OPCNT_W-1:0] ERASE_CYC =
    `SCS_FL_OPCNT_W'(`SCS_ERASE_CYC),
  parameter logic [`SCS_FL_OPCNT_W-1:0] PROG_CYC =
    `SCS_FL_OPCNT_W'(`SCS_PROG_CYC)
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`SCS_WAITST_W-1:0] waitStates,
  input wire logic fetchReq,
  input wire logic fetchFromRam,
  input wire logic [`SCS_FL_MOD_W-1:0] fetchModule,
  input wire logic [`SCS_FL_ADDR_W-1:0] fetchAddr,
  output logic fetchAck,
  output logic [`SCS_DATA_W-1:0] fetchData,
  output logic arrRdEn,
  output logic [`SCS_FL_MOD_W-1:0] arrModule,
  output logic [`SCS_FL_ADDR_W-1:0] arrAddr,
  input wire logic [`SCS_DATA_W-1:0] arrRdData,
  input wire logic opStart,
  input wire logic opErase,
  input wire logic [`SCS_FL_MOD_W-1:0] opModule,
  output logic opBusy,
  output logic opRefused
);

  scs_pkg::scs_flash_s s;
  scs_pkg::scs_flash_s n;
  logic blocked;
  logic take;
  logic hit;
  logic inFlight;

  always_comb
  begin
    n = s;
    n.ack = 1'b0;
    // A module under erase or program cannot deliver, so its fetches wait.
    blocked = !fetchFromRam && (s.opState != scs_pkg::SCS_OP_IDLE) &&
      (fetchModule == s.opModule);
    take = fetchReq && !s.ack && !blocked && !(s.engBusy && s.engDemand);
    hit = s.pfValid && (s.pfAddr == fetchAddr) && (s.pfModule == fetchModule);
    inFlight = s.engBusy && !s.engDemand && (s.engAddr == fetchAddr) &&
      (s.engModule == fetchModule);
    if (s.engBusy)
    begin
      if (s.engCnt == '0)
      begin
        n.engBusy = 1'b0;
        if (s.engDemand)
        begin
          n.ack = 1'b1;
          n.data = arrRdData;
          // Read the next word while the core digests this one.
          n.engBusy = 1'b1;
          n.engDemand = 1'b0;
          n.engAddr = s.engAddr + 16'h0001;
          n.engCnt = waitStates;
        end
        else
        begin
          n.pfValid = 1'b1;
          n.pfAddr = s.engAddr;
          n.pfModule = s.engModule;
          n.pfData = arrRdData;
        end
      end
      else
      begin
        n.engCnt = s.engCnt - 3'h1;
      end
    end
    if (take)
    begin
      if (fetchFromRam)
      begin
        n.ack = 1'b1;
        n.ramActive = 1'b1;
      end
      else
      begin
        n.ramActive = 1'b0;
        n.activeModule = fetchModule;
        if (hit)
        begin
          n.ack = 1'b1;
          n.data = s.pfData;
          n.pfValid = 1'b0;
          n.engBusy = 1'b1;
          n.engDemand = 1'b0;
          n.engAddr = fetchAddr + 16'h0001;
          n.engModule = fetchModule;
          n.engCnt = waitStates;
        end
        else if (inFlight)
        begin
          // Sequential fetch pays only what is left of the prefetch.
          if (s.engCnt != '0)
          begin
            n.engDemand = 1'b1;
          end
        end
        else
        begin
          n.pfValid = 1'b0;
          n.engBusy = 1'b1;
          n.engDemand = 1'b1;
          n.engAddr = fetchAddr;
          n.engModule = fetchModule;
          n.engCnt = waitStates;
        end
      end
    end
    case (s.opState)
      scs_pkg::SCS_OP_IDLE:
      begin
        if (opStart)
        begin
          if (!s.ramActive && (opModule == s.activeModule))
          begin
            n.refused = 1'b1;
          end
          else
          begin
            n.refused = 1'b0;
            n.opState = scs_pkg::SCS_OP_OVERHEAD;
            n.opErase = opErase;
            n.opModule = opModule;
            n.opCnt = `SCS_FL_OVERHEAD_CYC - 20'h00001;
          end
        end
      end
      scs_pkg::SCS_OP_OVERHEAD:
      begin
        if (opStart)
        begin
          n.refused = 1'b1;
        end
        if (s.opCnt == '0)
        begin
          n.opState = scs_pkg::SCS_OP_TIMED;
          n.opCnt = (s.opErase ? ERASE_CYC : PROG_CYC) - 20'h00001;
        end
        else
        begin
          n.opCnt = s.opCnt - 20'h00001;
        end
      end
      scs_pkg::SCS_OP_TIMED:
      begin
        if (opStart)
        begin
          n.refused = 1'b1;
        end
        if (s.opCnt == '0)
        begin
          n.opState = scs_pkg::SCS_OP_IDLE;
        end
        else
        begin
          n.opCnt = s.opCnt - 20'h00001;
        end
      end
      default:
      begin
        n.opState = scs_pkg::SCS_OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.ramActive <= 1'b1;
      s.opState <= scs_pkg::SCS_OP_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  assign fetchAck = s.ack;
  assign fetchData = s.data;
  assign arrRdEn = s.engBusy;
  assign arrModule = s.engModule;
  assign arrAddr = s.engAddr;
  assign opBusy = (s.opState != scs_pkg::SCS_OP_IDLE);
  assign opRefused = s.refused;

endmodule : scs_flash_ctl

// *** tb/scs_clock_select_properties.sv ***
// Concurrent checks on the ports of the clock select top level.
`include "scs_consts.svh"

module scs_clock_select_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`SCS_ADDR_W-1:0] regAddr,
  input wire logic [`SCS_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [`SCS_DATA_W-1:0] regRdData,
  input wire logic wakeupClkIn,
  input wire logic pllClkIn,
  input wire logic directClkIn,
  input wire logic crystalIn,
  input wire logic intClkIn,
  input wire logic sysClk,
  input wire logic pllEnable,
  input wire logic fetchReq,
  input wire logic fetchAck,
  input wire logic [`SCS_DATA_W-1:0] fetchData
);
  typedef struct packed {
    logic [1:0] sel;
    logic byp;
    logic osc;
    logic [`SCS_PREDIV_W-1:0] div;
    logic [7:0] quiet;
  } scs_chk_s;
  scs_chk_s st_r, st_nxt;
  logic settled;

  // A switch may wait out a whole old period, so tracking is only judged
  // once the configuration has been left alone for a while.
  assign settled = st_r.quiet > 8'h96;

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.quiet != 8'hFF)
      st_nxt.quiet = st_r.quiet + 8'h01;
    if (regWr && regAddr == `SCS_ADDR_SYSCTL0)
    begin
      if (regWrData[1:0] != 2'h1)
        st_nxt.sel = regWrData[1:0];
      st_nxt.quiet = 8'h00;
    end
    if (regWr && regAddr == `SCS_ADDR_PLLCTL0)
    begin
      st_nxt.byp = regWrData[`SCS_BYPASS_BIT];
      st_nxt.osc = regWrData[`SCS_OSCINT_BIT];
      st_nxt.div = regWrData[`SCS_PREDIV_LSB +: `SCS_PREDIV_W];
      st_nxt.quiet = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      st_r <= '{`SCS_RST_SRCSEL, `SCS_RST_BYPASS, `SCS_RST_OSCINT,
                `SCS_RST_PREDIV, 8'h00};
    else
      st_r <= st_nxt;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_rise;
    $rose(sysClk);
  endsequence
  sequence s_fall;
    $fell(sysClk);
  endsequence

  AST_RD_IDLE_ZERO: assert property (
    !$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data not zero outside a read answer");
  AST_ACK_ONE_CYCLE: assert property (fetchAck |=> !fetchAck)
    else $error("fetch acknowledge longer than one cycle");
  AST_ACK_HAS_REQ: assert property (
    fetchAck |-> fetchReq && $past(fetchReq))
    else $error("fetch acknowledge without a held request");
  AST_DATA_HOLDS: assert property (!fetchAck |-> $stable(fetchData))
    else $error("fetch data changed without acknowledge");
  AST_DIRECT_TRACK: assert property (
    (settled && st_r.sel == 2'h3) |-> sysClk == $past(directClkIn, 3))
    else $error("system clock does not track direct input");
  AST_WAKE_TRACK: assert property (
    (settled && st_r.sel == 2'h0) |-> sysClk == $past(wakeupClkIn, 3))
    else $error("system clock does not track wakeup input");
  AST_DIV1_TRACK: assert property (
    (settled && st_r.sel == 2'h2 && st_r.byp && st_r.div == 10'h000)
    |-> sysClk == (st_r.osc ? $past(intClkIn, 3) : $past(crystalIn, 3)))
    else $error("factor one does not pass the source through");
  AST_PLL_ENABLED: assert property (
    (settled && st_r.sel == 2'h2 && !st_r.byp) |-> pllEnable)
    else $error("loop not enabled while selected");
  AST_PLL_TRACK: assert property (
    (settled && st_r.sel == 2'h2 && !st_r.byp && st_r.div == 10'h000)
    |-> sysClk == $past(pllClkIn, 3))
    else $error("system clock does not track loop output");
  AST_NO_RUNT_HIGH: assert property (s_rise |=> sysClk)
    else $error("short high pulse on system clock");
  AST_NO_RUNT_LOW: assert property (s_fall |=> !sysClk)
    else $error("short low pulse on system clock");
endmodule : scs_clock_select_checker

bind scs_clock_select scs_clock_select_checker chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .wakeupClkIn(wakeupClkIn), .pllClkIn(pllClkIn),
  .directClkIn(directClkIn), .crystalIn(crystalIn), .intClkIn(intClkIn),
  .sysClk(sysClk), .pllEnable(pllEnable), .fetchReq(fetchReq),
  .fetchAck(fetchAck), .fetchData(fetchData));

// *** tb/scs_clock_select_bench.sv ***
// Self-checking bench for the clock select and flash timing block.
`include "scs_consts.svh"

`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %0h expected %0h", $time, (a), (e)); end end

module scs_clock_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ERA = 20;
  localparam int PRG = 40;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [`SCS_ADDR_W-1:0] regAddr = 4'h0;
  logic [`SCS_DATA_W-1:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic wakeupClkIn = 1'b0, pllClkIn = 1'b0, directClkIn = 1'b0;
  logic crystalIn = 1'b0, intClkIn = 1'b0;
  logic fetchReq = 1'b0, fetchFromRam = 1'b0;
  logic [`SCS_FL_MOD_W-1:0] fetchModule = 2'h0;
  logic [`SCS_FL_ADDR_W-1:0] fetchAddr = 16'h0000;
  logic [`SCS_DATA_W-1:0] regRdData, fetchData, arrRdData;
  logic sysClk, pllEnable, fetchAck, arrRdEn;
  logic [`SCS_FL_MOD_W-1:0] arrModule;
  logic [`SCS_FL_ADDR_W-1:0] arrAddr;
  int err_total = 0;
  int checks_done = 0;
  int tick = 0;
  int cycles = 0;

  // Array content depends on module and address, so misrouting shows up.
  assign arrRdData = arrAddr ^ 16'h5A5A ^ {14'h0000, arrModule};

  scs_clock_select #(.ERASE_CYC(ERA), .PROG_CYC(PRG)) dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .wakeupClkIn(wakeupClkIn), .pllClkIn(pllClkIn),
    .directClkIn(directClkIn), .crystalIn(crystalIn), .intClkIn(intClkIn),
    .sysClk(sysClk), .pllEnable(pllEnable), .fetchReq(fetchReq),
    .fetchFromRam(fetchFromRam), .fetchModule(fetchModule),
    .fetchAddr(fetchAddr), .fetchAck(fetchAck), .fetchData(fetchData),
    .arrRdEn(arrRdEn), .arrModule(arrModule), .arrAddr(arrAddr),
    .arrRdData(arrRdData));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Sources toggle every 7, 3, 5, 6 and 4 cycles, all slower than a quarter.
  always @(posedge ref_clk)
  begin
    tick <= tick + 1;
    wakeupClkIn <= ((tick / 7) % 2) == 1;
    pllClkIn <= ((tick / 3) % 2) == 1;
    directClkIn <= ((tick / 5) % 2) == 1;
    crystalIn <= ((tick / 6) % 2) == 1;
    intClkIn <= ((tick / 4) % 2) == 1;
  end

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report;
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
    v = regRdData;
  endtask : reg_rd

  task automatic fetch(input logic ram, input logic [1:0] m,
                       input logic [15:0] a, output int lat);
    repeat (8) @(posedge ref_clk);
    fetchReq <= 1'b1;
    fetchFromRam <= ram;
    fetchModule <= m;
    fetchAddr <= a;
    lat = 0;
    do
    begin
      @(posedge ref_clk);
      lat++;
    end while (fetchAck !== 1'b1);
    fetchReq <= 1'b0;
  endtask : fetch

  task automatic rise;
    while (sysClk !== 1'b0) @(posedge ref_clk);
    while (sysClk !== 1'b1) @(posedge ref_clk);
  endtask : rise

  // The first rises after a change may still belong to the old source.
  // The long wait also lets the checker judge each settled source.
  task automatic clk_measure(output int hi, output int per);
    repeat (152) @(posedge ref_clk);
    repeat (3) rise();
    hi = 0;
    per = 0;
    while (sysClk === 1'b1)
    begin
      hi++;
      per++;
      @(posedge ref_clk);
    end
    while (sysClk === 1'b0)
    begin
      per++;
      @(posedge ref_clk);
    end
  endtask : clk_measure

  task automatic test_regs;
    logic [15:0] d;
    reg_rd(`SCS_ADDR_PLLCTL0, d);
    `CHK(d, 16'h0003)
    reg_wr(4'hF, 16'hFFFF);
    reg_rd(`SCS_ADDR_FLCTL, d);
    `CHK(d, 16'h0004)
    reg_rd(4'hF, d);
    `CHK(d, 16'h0000)
  endtask : test_regs

  task automatic test_clocks;
    int hi, per;
    logic [15:0] d;
    clk_measure(hi, per);
    `CHK({hi, per}, {32'd7, 32'd14})
    reg_wr(`SCS_ADDR_SYSCTL0, 16'h0003);
    clk_measure(hi, per);
    `CHK({hi, per}, {32'd5, 32'd10})
    reg_wr(`SCS_ADDR_PLLCTL0, 16'h0003);
    reg_wr(`SCS_ADDR_SYSCTL0, 16'h0002);
    clk_measure(hi, per);
    `CHK({hi, per}, {32'd4, 32'd8})
    reg_wr(`SCS_ADDR_PLLCTL0, 16'h000B);
    clk_measure(hi, per);
    `CHK({hi, per}, {32'd12, 32'd24})
    reg_wr(`SCS_ADDR_PLLCTL0, 16'h0009);
    clk_measure(hi, per);
    `CHK({hi, per}, {32'd18, 32'd36})
    reg_wr(`SCS_ADDR_PLLCTL0, 16'h0002);
    clk_measure(hi, per);
    `CHK({hi, per, pllEnable}, {32'd3, 32'd6, 1'b1})
    reg_wr(`SCS_ADDR_PLLCTL0, 16'h0FFF);
    clk_measure(hi, per);
    `CHK({hi, per}, {32'd4096, 32'd8192})
    reg_rd(`SCS_ADDR_CLKSTAT, d);
    `CHK(d[11:0], 12'hFFE)
    `CHK(pllEnable, 1'b0)
  endtask : test_clocks

  task automatic test_fetch;
    int lat;
    reg_wr(`SCS_ADDR_FLCTL, 16'h0001);
    fetch(1'b0, 2'h1, 16'h0100, lat);
    `CHK({lat, fetchData}, {32'd4, 16'h5B5B})
    `CHK({arrRdEn, arrAddr}, {1'b1, 16'h0101})
    fetch(1'b0, 2'h1, 16'h0101, lat);
    `CHK({lat, fetchData}, {32'd2, 16'h5B5A})
    reg_wr(`SCS_ADDR_FLCTL, 16'h0003);
    fetch(1'b0, 2'h1, 16'h0200, lat);
    `CHK({lat, fetchData}, {32'd6, 16'h585B})
    fetch(1'b1, 2'h2, 16'h0000, lat);
    `CHK(lat, 2)
  endtask : test_fetch

  task automatic test_flash_op;
    int lat, ones;
    logic [15:0] d;
    fetch(1'b0, 2'h1, 16'h0300, lat);
    reg_wr(`SCS_ADDR_FLCMD, 16'h0003);
    reg_rd(`SCS_ADDR_FLCMD, d);
    `CHK(d[1:0], 2'h2)
    reg_wr(`SCS_ADDR_FLCMD, 16'h0005);
    ones = 0;
    regRd <= 1'b1;
    regAddr <= `SCS_ADDR_FLCMD;
    repeat (60)
    begin
      @(posedge ref_clk);
      if (regRdData[0] === 1'b1) ones++;
    end
    regRd <= 1'b0;
    `CHK(ones, 4 + ERA)
    reg_wr(`SCS_ADDR_FLCMD, 16'h0004);
    fetch(1'b0, 2'h0, 16'h0400, lat);
    `CHK(lat, 6)
    fetch(1'b0, 2'h2, 16'h0500, lat);
    `CHK(lat > 6, 1'b1)
  endtask : test_flash_op

  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    test_regs();
    test_clocks();
    test_fetch();
    test_flash_op();
    final_report();
  end
endmodule : scs_clock_select_bench
